/* File: src/phy_vendor_status_regs.sv */
// Vendor management registers: event interrupt, error and loss tallies,
// strap capture and transmit power saving controls.
// Assumes frame logic on mclk_in issues one-cycle read/write strobes;
// link state inputs come from same-clock logic, straps from pins.
`timescale 1ns/1ps
module phy_vendor_status_regs #(
  parameter int RXERR_W = 16,
  parameter int LOSS_W  = 8
) (
  input  wire logic                  mclk_in,
  input  wire logic                  arst_n_in,
  input  wire logic [4:0]            mgmt_addr_in,
  input  wire logic                  mgmt_wr_in,
  input  wire logic                  mgmt_rd_in,
  input  wire logic [15:0]           mgmt_wdata_in,
  output logic      [15:0]           mgmt_rdata_out,
  output logic                       mgmt_rvalid_out,
  input  wire logic                  duplex_state_in,
  input  wire logic                  speed_state_in,
  input  wire logic                  link_state_in,
  input  wire logic                  rx_error_in,
  input  wire logic                  link_drop_in,
  input  wire phy_vendor_pkg::strap_t strap_levels_in,
  output phy_vendor_pkg::strap_t     strap_state_out,
  output logic                       mgmt_irq_out_n,
  output logic                       tx10_power_saving_out,
  output logic      [4:0]            preamble_cut_out,
  output logic                       tx_drive_reduce_out
);
  typedef struct packed {
    phy_vendor_pkg::irq_mask_t    msk;
    phy_vendor_pkg::event_flags_t flg;
    logic                         irq_status_flag;
    logic                         dup_prev;
    logic                         spd_prev;
    logic                         link_prev;
    logic                         primed;
    phy_vendor_pkg::strap_t       strap;
    logic                         strap_done;
    logic [1:0]                   settle_cnt;
    logic                         preamble_normal;
    logic                         tx10_power_saving_en;
    logic                         preamble_cut_size;
    logic                         tx_drive_saving_off;
    logic [4:0]                   preamble_cut;
    logic                         drive_reduce;
    logic [15:0]                  rdata;
    logic                         rvalid;
  } state_t;

  localparam state_t ST_RESET = '{
    msk:     '1,
    strap:   phy_vendor_pkg::STRAP_RESET,
    default: '0
  };

  generate
    if (RXERR_W < 1 || RXERR_W > 16 || LOSS_W < 1 || LOSS_W > 16)
    begin : g_bad_width
      $error("tally widths must be 1 to 16");
    end
  endgenerate

  state_t               st;
  state_t               next_st;
  logic   [15:0]        strap_sync;
  logic   [RXERR_W-1:0] rx_count;
  logic   [LOSS_W-1:0]  loss_count;
  logic   [15:0]        rd_word;
  logic   [2:0]         blocks;
  logic                 raise;
  logic                 rd_irq;
  logic                 wr_irq;
  logic                 rd_rx;
  logic                 rd_loss;
  logic                 wr_strap;
  logic                 wr_cfg;
  logic                 wr_save;
  logic                 dup_evt;
  logic                 spd_evt;
  logic                 link_evt;

  assign rd_irq   = mgmt_rd_in && mgmt_addr_in == phy_vendor_pkg::IRQ_ADDR;
  assign wr_irq   = mgmt_wr_in && mgmt_addr_in == phy_vendor_pkg::IRQ_ADDR;
  assign rd_rx    = mgmt_rd_in && mgmt_addr_in == phy_vendor_pkg::RXERR_ADDR;
  assign rd_loss  = mgmt_rd_in && mgmt_addr_in == phy_vendor_pkg::LOSS_ADDR;
  assign wr_strap = mgmt_wr_in && mgmt_addr_in == phy_vendor_pkg::STRAP_ADDR;
  assign wr_cfg   = mgmt_wr_in && mgmt_addr_in == phy_vendor_pkg::CFG_ADDR;
  assign wr_save  = mgmt_wr_in && mgmt_addr_in == phy_vendor_pkg::SAVE_ADDR;

  // First cycle after reset has no history, so no change is reported
  assign dup_evt  = st.primed && (duplex_state_in != st.dup_prev);
  assign spd_evt  = st.primed && (speed_state_in != st.spd_prev);
  assign link_evt = st.primed && (link_state_in != st.link_prev);

  level_sync #(
    .W (16)
  ) u_strap_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .level_in  (strap_levels_in),
    .level_out (strap_sync)
  );

  event_tally #(
    .W (RXERR_W)
  ) u_rx_tally (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .event_in  (rx_error_in),
    .clear_in  (rd_rx),
    .count_out (rx_count)
  );

  event_tally #(
    .W (LOSS_W)
  ) u_loss_tally (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .event_in  (link_drop_in),
    .clear_in  (rd_loss),
    .count_out (loss_count)
  );

  always_comb begin
    rd_word = '0;
    case (mgmt_addr_in)
      phy_vendor_pkg::IRQ_ADDR: begin
        rd_word[phy_vendor_pkg::PEND_BIT]     = st.irq_status_flag;
        rd_word[phy_vendor_pkg::DUP_BLK_BIT]  = st.msk.duplex_event_block;
        rd_word[phy_vendor_pkg::SPD_BLK_BIT]  = st.msk.speed_event_block;
        rd_word[phy_vendor_pkg::LINK_BLK_BIT] = st.msk.link_event_block;
        rd_word[phy_vendor_pkg::GLB_BLK_BIT]  = st.msk.global_irq_block;
        rd_word[phy_vendor_pkg::DUP_CHG_BIT]  = st.flg.duplex_changed_flag;
        rd_word[phy_vendor_pkg::SPD_CHG_BIT]  = st.flg.speed_changed_flag;
        rd_word[phy_vendor_pkg::LINK_CHG_BIT] = st.flg.link_changed_flag;
        rd_word[phy_vendor_pkg::STATUS_BIT]   = st.irq_status_flag;
      end
      phy_vendor_pkg::RXERR_ADDR: begin
        rd_word = 16'(rx_count);
      end
      phy_vendor_pkg::LOSS_ADDR: begin
        rd_word = 16'(loss_count);
      end
      phy_vendor_pkg::STRAP_ADDR: begin
        rd_word = st.strap;
      end
      phy_vendor_pkg::CFG_ADDR: begin
        rd_word[phy_vendor_pkg::PRE_NORMAL_BIT] = st.preamble_normal;
        rd_word[phy_vendor_pkg::TX10_EN_BIT]    = st.tx10_power_saving_en;
      end
      phy_vendor_pkg::SAVE_ADDR: begin
        rd_word[phy_vendor_pkg::CUT_SIZE_BIT]  = st.preamble_cut_size;
        rd_word[phy_vendor_pkg::DRIVE_OFF_BIT] = st.tx_drive_saving_off;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_comb begin
    next_st           = st;
    next_st.primed    = 1'b1;
    next_st.dup_prev  = duplex_state_in;
    next_st.spd_prev  = speed_state_in;
    next_st.link_prev = link_state_in;

    if (wr_irq) begin
      next_st.msk.duplex_event_block =
        mgmt_wdata_in[phy_vendor_pkg::DUP_BLK_BIT];
      next_st.msk.speed_event_block =
        mgmt_wdata_in[phy_vendor_pkg::SPD_BLK_BIT];
      next_st.msk.link_event_block =
        mgmt_wdata_in[phy_vendor_pkg::LINK_BLK_BIT];
      next_st.msk.global_irq_block =
        mgmt_wdata_in[phy_vendor_pkg::GLB_BLK_BIT];
    end

    if (rd_irq) begin
      next_st.flg = '0;
    end
    if (dup_evt) begin
      next_st.flg.duplex_changed_flag = 1'b1;
    end
    if (spd_evt) begin
      next_st.flg.speed_changed_flag = 1'b1;
    end
    if (link_evt) begin
      next_st.flg.link_changed_flag = 1'b1;
    end

    blocks = {next_st.msk.duplex_event_block,
              next_st.msk.speed_event_block,
              next_st.msk.link_event_block};
    raise  = !next_st.msk.global_irq_block && |(next_st.flg & ~blocks);
    next_st.irq_status_flag = (st.irq_status_flag && !rd_irq) || raise;

    if (!st.strap_done) begin
      if (st.settle_cnt == phy_vendor_pkg::STRAP_SETTLE) begin
        next_st.strap      = phy_vendor_pkg::strap_t'(strap_sync);
        next_st.strap_done = 1'b1;
      end else begin
        next_st.settle_cnt = st.settle_cnt + 2'h1;
      end
    end else if (wr_strap) begin
      // Only bits 12 to 8 take writes
      next_st.strap = phy_vendor_pkg::strap_t'(
        (st.strap & ~phy_vendor_pkg::STRAP_RW_MASK) |
        (mgmt_wdata_in & phy_vendor_pkg::STRAP_RW_MASK));
    end

    if (wr_cfg) begin
      next_st.preamble_normal =
        mgmt_wdata_in[phy_vendor_pkg::PRE_NORMAL_BIT];
      next_st.tx10_power_saving_en =
        mgmt_wdata_in[phy_vendor_pkg::TX10_EN_BIT];
    end
    if (wr_save) begin
      next_st.preamble_cut_size =
        mgmt_wdata_in[phy_vendor_pkg::CUT_SIZE_BIT];
      next_st.tx_drive_saving_off =
        mgmt_wdata_in[phy_vendor_pkg::DRIVE_OFF_BIT];
    end

    if (next_st.tx10_power_saving_en && !next_st.preamble_normal) begin
      next_st.preamble_cut = next_st.preamble_cut_size ?
        phy_vendor_pkg::CUT_SHORT : phy_vendor_pkg::CUT_LONG;
    end else begin
      next_st.preamble_cut = phy_vendor_pkg::CUT_NONE;
    end

    next_st.drive_reduce = !next_st.tx_drive_saving_off && !link_state_in;

    // Read data holds until the next read
    next_st.rvalid = mgmt_rd_in;
    if (mgmt_rd_in) begin
      next_st.rdata = rd_word;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign mgmt_rdata_out        = st.rdata;
  assign mgmt_rvalid_out       = st.rvalid;
  assign strap_state_out       = st.strap;
  assign mgmt_irq_out_n        = !st.irq_status_flag;
  assign tx10_power_saving_out = st.tx10_power_saving_en;
  assign preamble_cut_out      = st.preamble_cut;
  assign tx_drive_reduce_out   = st.drive_reduce;

  logic [15:0] strap_ro;
  logic [15:0] strap_rw;
  logic [15:0] wdata_rw;
  logic        any_evt;

  assign strap_ro = st.strap & ~phy_vendor_pkg::STRAP_RW_MASK;
  assign strap_rw = st.strap & phy_vendor_pkg::STRAP_RW_MASK;
  assign wdata_rw = mgmt_wdata_in & phy_vendor_pkg::STRAP_RW_MASK;
  assign any_evt  = dup_evt || spd_evt || link_evt;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_pend_mirror;
    rd_irq |=> mgmt_rvalid_out &&
      mgmt_rdata_out[phy_vendor_pkg::PEND_BIT] ==
      mgmt_rdata_out[phy_vendor_pkg::STATUS_BIT];
  endproperty
  a_pend_mirror: assert property (p_pend_mirror)
    else $error("pending bit differs from status bit");

  property p_read_clears;
    rd_irq && !any_evt |=> !st.irq_status_flag && mgmt_irq_out_n;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

  property p_all_blocked;
    st.msk.duplex_event_block && st.msk.speed_event_block &&
      st.msk.link_event_block && !st.irq_status_flag && !wr_irq
      |=> !st.irq_status_flag;
  endproperty
  a_all_blocked: assert property (p_all_blocked)
    else $error("blocked event raised interrupt");

  property p_global_block;
    st.msk.global_irq_block && !st.irq_status_flag && !wr_irq
      |=> !st.irq_status_flag && mgmt_irq_out_n;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("interrupt raised under global block");

  property p_dup_latch;
    dup_evt |=> st.flg.duplex_changed_flag;
  endproperty
  a_dup_latch: assert property (p_dup_latch)
    else $error("duplex change not latched");

  property p_spd_latch;
    spd_evt |=> st.flg.speed_changed_flag;
  endproperty
  a_spd_latch: assert property (p_spd_latch)
    else $error("speed change flag lost");

  property p_link_hold;
    st.flg.link_changed_flag && !rd_irq |=> st.flg.link_changed_flag;
  endproperty
  a_link_hold: assert property (p_link_hold)
    else $error("link change flag dropped without read");

  property p_irq_raise;
    !st.msk.global_irq_block && !rd_irq && !wr_irq &&
      (st.flg & ~{st.msk.duplex_event_block, st.msk.speed_event_block,
                  st.msk.link_event_block}) != 3'h0
      |=> st.irq_status_flag ##0 !mgmt_irq_out_n;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("unblocked flag did not raise interrupt");

  property p_rx_clear;
    rd_rx && !rx_error_in |=> rx_count == '0;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("error tally not cleared by read");

  property p_loss_upper;
    rd_loss |=> mgmt_rdata_out[15:8] == 8'h00;
  endproperty
  a_loss_upper: assert property (p_loss_upper)
    else $error("loss tally upper byte not zero");

  property p_strap_ro;
    st.strap_done |=> $stable(strap_ro);
  endproperty
  a_strap_ro: assert property (p_strap_ro)
    else $error("read-only strap bits changed");

  property p_strap_rw;
    st.strap_done && wr_strap |=> strap_rw == $past(wdata_rw);
  endproperty
  a_strap_rw: assert property (p_strap_rw)
    else $error("writable strap bits not written");

  property p_preamble;
    st.tx10_power_saving_en && !st.preamble_normal && !wr_cfg && !wr_save
      |=> preamble_cut_out == ($past(st.preamble_cut_size) ?
          phy_vendor_pkg::CUT_SHORT : phy_vendor_pkg::CUT_LONG);
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("wrong preamble cut");

  property p_no_saving;
    !st.tx10_power_saving_en |-> preamble_cut_out == phy_vendor_pkg::CUT_NONE;
  endproperty
  a_no_saving: assert property (p_no_saving)
    else $error("preamble cut without power saving");

  property p_drive;
    !st.tx_drive_saving_off && !wr_save && !link_state_in
      |=> tx_drive_reduce_out;
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive not reduced without link");

  property p_rx_keep;
    rd_rx && rx_error_in |=> rx_count == RXERR_W'(1);
  endproperty
  a_rx_keep: assert property (p_rx_keep)
    else $error("error lost at clear-on-read");

  c_irq_rise: cover property ($rose(st.irq_status_flag));
  c_rx_clear: cover property (rd_rx && rx_count != '0);
  c_strap_wr: cover property (st.strap_done && wr_strap);
  c_cut_short: cover property (preamble_cut_out == phy_vendor_pkg::CUT_SHORT);
endmodule

/* File: src/phy_vendor_pkg.sv */
// Constants and carrier types for the vendor management register bank.
// Assumes a 5-bit register address and 16-bit data from the frame logic.
package phy_vendor_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  localparam logic [4:0] CFG_ADDR   = 5'h14;
  localparam logic [4:0] IRQ_ADDR   = 5'h15;
  localparam logic [4:0] RXERR_ADDR = 5'h16;
  localparam logic [4:0] LOSS_ADDR  = 5'h17;
  localparam logic [4:0] STRAP_ADDR = 5'h18;
  localparam logic [4:0] SAVE_ADDR  = 5'h1d;

  // Interrupt register fields
  localparam int PEND_BIT     = 15;
  localparam int DUP_BLK_BIT  = 11;
  localparam int SPD_BLK_BIT  = 10;
  localparam int LINK_BLK_BIT = 9;
  localparam int GLB_BLK_BIT  = 8;
  localparam int DUP_CHG_BIT  = 4;
  localparam int SPD_CHG_BIT  = 3;
  localparam int LINK_CHG_BIT = 2;
  localparam int STATUS_BIT   = 0;

  // Configuration and power saving fields
  localparam int PRE_NORMAL_BIT = 11;
  localparam int TX10_EN_BIT    = 10;
  localparam int CUT_SIZE_BIT   = 11;
  localparam int DRIVE_OFF_BIT  = 9;

  localparam logic [15:0] STRAP_RESET   = 16'hc4e0;
  localparam logic [15:0] STRAP_RW_MASK = 16'h1f00;

  localparam logic [4:0] CUT_SHORT = 5'h0a;
  localparam logic [4:0] CUT_LONG  = 5'h14;
  localparam logic [4:0] CUT_NONE  = 5'h00;

  // Cycles after reset release before synchronised straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic       strap_led_style;
    logic       strap_irq_pin;
    logic       strap_cable_state;
    logic       strap_isolate;
    logic       strap_reduced_pin_mode;
    logic       strap_10m_serial;
    logic       strap_repeater;
    logic       strap_test_mode;
    logic [2:0] strap_opmode;
    logic [4:0] strap_phy_addr;
  } strap_t;

  typedef struct packed {
    logic duplex_event_block;
    logic speed_event_block;
    logic link_event_block;
    logic global_irq_block;
  } irq_mask_t;

  typedef struct packed {
    logic duplex_changed_flag;
    logic speed_changed_flag;
    logic link_changed_flag;
  } event_flags_t;
endpackage

/* File: src/level_sync.sv */
// Two-stage synchroniser for a group of slow asynchronous levels.
// Assumes the levels are quasi-static; bits may land a cycle apart.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  generate
    if (W < 1) begin : g_bad_width
      $error("level_sync width must be positive");
    end
  endgenerate

  always_comb begin
    next_st    = st;
    next_st.s1 = level_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.s2;
endmodule

/* File: src/event_tally.sv */
// Clear-on-read event counter that wraps at its width.
// Assumes event and clear are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module event_tally #(
  parameter int W = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         arst_n_in,
  input  wire logic         event_in,
  input  wire logic         clear_in,
  output logic      [W-1:0] count_out
);
  typedef struct packed {
    logic [W-1:0] count;
  } tally_state_t;

  tally_state_t st;
  tally_state_t next_st;

  generate
    if (W < 1 || W > 16) begin : g_bad_width
      $error("event_tally width must be 1 to 16");
    end
  endgenerate

  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.count = W'(event_in);
    end else if (event_in) begin
      next_st.count = st.count + W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_out = st.count;
endmodule

/* File: testbench/mgmt_station_model.sv */
// Station management model: issues one-cycle read and write strobes.
// Assumes the bank answers a read with a valid pulse a cycle later.
`timescale 1ns/1ps
module mgmt_station_model (
  input  wire logic        mclk_in,
  output logic [4:0]       mgmt_addr_out,
  output logic             mgmt_wr_out,
  output logic             mgmt_rd_out,
  output logic [15:0]      mgmt_wdata_out,
  input  wire logic [15:0] mgmt_rdata_in,
  input  wire logic        mgmt_rvalid_in
);
  initial begin
    mgmt_addr_out  = 5'h00;
    mgmt_wr_out    = 1'b0;
    mgmt_rd_out    = 1'b0;
    mgmt_wdata_out = 16'h0000;
  end

  // Released lines show inverted data so stale values never match
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    mgmt_addr_out  = a;
    mgmt_wdata_out = d;
    mgmt_wr_out    = 1'b1;
    @(negedge mclk_in);
    mgmt_wr_out    = 1'b0;
    mgmt_addr_out  = ~a;
    mgmt_wdata_out = ~d;
  endtask

  task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
    d = 16'hxxxx;
    @(negedge mclk_in);
    mgmt_addr_out = a;
    mgmt_rd_out   = 1'b1;
    @(negedge mclk_in);
    mgmt_rd_out   = 1'b0;
    mgmt_addr_out = ~a;
    for (int k = 0; k < 4; k++) begin
      if (mgmt_rvalid_in === 1'b1) begin
        d = mgmt_rdata_in;
        break;
      end
      @(negedge mclk_in);
    end
  endtask
endmodule

/* File: testbench/phy_vendor_status_regs_tb_top.sv */
// Self-checking bench for the vendor management register bank.
// Assumes the station model drives the register port at falling edges.
`timescale 1ns/1ps
module phy_vendor_status_regs_tb_top;
  localparam logic [15:0] STRAPS = 16'h3a6b;
  logic                   mclk_in;
  logic                   arst_n_in;
  logic [4:0]             addr;
  logic                   wr;
  logic                   rd;
  logic [15:0]            wdata;
  logic [15:0]            rdata;
  logic                   rvalid;
  logic [2:0]             lvl;
  logic                   rx_err;
  logic                   drop;
  phy_vendor_pkg::strap_t strap_st;
  phy_vendor_pkg::strap_t pins;
  logic                   irq_n;
  logic                   tx10;
  logic [4:0]             cut;
  logic                   reduce;
  logic [15:0]            d;
  int                     n_mismatch;
  int                     n_checks;

  mgmt_station_model u_sta (
    .mclk_in(mclk_in), .mgmt_addr_out(addr), .mgmt_wr_out(wr),
    .mgmt_rd_out(rd), .mgmt_wdata_out(wdata), .mgmt_rdata_in(rdata),
    .mgmt_rvalid_in(rvalid));

  phy_vendor_status_regs #(.RXERR_W(16), .LOSS_W(8)) u_dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .mgmt_addr_in(addr),
    .mgmt_wr_in(wr), .mgmt_rd_in(rd), .mgmt_wdata_in(wdata),
    .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid),
    .duplex_state_in(lvl[2]), .speed_state_in(lvl[1]),
    .link_state_in(lvl[0]), .rx_error_in(rx_err), .link_drop_in(drop),
    .strap_levels_in(pins),
    .strap_state_out(strap_st), .mgmt_irq_out_n(irq_n),
    .tx10_power_saving_out(tx10), .preamble_cut_out(cut),
    .tx_drive_reduce_out(reduce));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(logic [4:0] a, logic [15:0] exp);
    u_sta.read_reg(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  task automatic toggle(int i);
    @(negedge mclk_in);
    lvl[i] = ~lvl[i];
    repeat (3) @(negedge mclk_in);
  endtask

  initial begin
    #200us;
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    arst_n_in = 1'b0;
    lvl = 3'b000;
    rx_err = 1'b0;
    drop = 1'b0;
    pins = STRAPS;
    repeat (3) @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    rd_chk(5'h14, 16'h0000);
    rd_chk(5'h1d, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    rd_chk(5'h18, STRAPS);
    // Pins move after capture; the register must not follow them
    pins = ~STRAPS;
    u_sta.write_reg(5'h18, 16'hffff);
    u_sta.write_reg(5'h1f, 16'hffff);
    rd_chk(5'h18, STRAPS | 16'h1f00);
    chk("strap out", strap_st, STRAPS | 16'h1f00);
    rd_chk(5'h1f, 16'h0000);
    toggle(0);
    chk("irq_n reset masks", 16'(irq_n), 16'h0001);
    rd_chk(5'h15, 16'h0f04);
    u_sta.write_reg(5'h15, 16'h0100);
    toggle(1);
    toggle(0);
    chk("irq_n global", 16'(irq_n), 16'h0001);
    rd_chk(5'h15, 16'h010c);
    for (int i = 0; i < 3; i++) begin
      u_sta.write_reg(5'h15, 16'h0001 << (9 + i));
      toggle(i);
      chk("irq_n blocked", 16'(irq_n), 16'h0001);
      rd_chk(5'h15, (16'h0001 << (9 + i)) | (16'h0001 << (2 + i)));
      u_sta.write_reg(5'h15, 16'h0000);
      toggle(i);
      chk("irq_n raised", 16'(irq_n), 16'h0000);
      rd_chk(5'h15, 16'h8001 | (16'h0001 << (2 + i)));
      repeat (2) @(negedge mclk_in);
      chk("irq_n cleared", 16'(irq_n), 16'h0001);
      rd_chk(5'h15, 16'h0000);
    end
    repeat (3) begin
      @(negedge mclk_in);
      rx_err = 1'b1;
      @(negedge mclk_in);
      rx_err = 1'b0;
    end
    rd_chk(5'h16, 16'h0003);
    rd_chk(5'h16, 16'h0000);
    fork
      u_sta.read_reg(5'h16, d);
      begin
        @(negedge mclk_in);
        rx_err = 1'b1;
        @(negedge mclk_in);
        rx_err = 1'b0;
      end
    join
    chk("rx tally old", d, 16'h0000);
    rd_chk(5'h16, 16'h0001);
    repeat (257) begin
      @(negedge mclk_in);
      drop = 1'b1;
      @(negedge mclk_in);
      drop = 1'b0;
    end
    rd_chk(5'h17, 16'h0001);
    rd_chk(5'h17, 16'h0000);
    u_sta.write_reg(5'h14, 16'h0400);
    u_sta.write_reg(5'h1d, 16'h0800);
    @(negedge mclk_in);
    chk("tx10 out", 16'(tx10), 16'h0001);
    chk("cut short", 16'(cut), 16'h000a);
    rd_chk(5'h1d, 16'h0800);
    u_sta.write_reg(5'h1d, 16'h0000);
    @(negedge mclk_in);
    chk("cut long", 16'(cut), 16'h0014);
    u_sta.write_reg(5'h14, 16'h0c00);
    @(negedge mclk_in);
    chk("cut none", 16'(cut), 16'h0000);
    rd_chk(5'h14, 16'h0c00);
    @(negedge mclk_in);
    lvl[0] = 1'b0;
    repeat (3) @(negedge mclk_in);
    chk("drive reduce", 16'(reduce), 16'h0001);
    u_sta.write_reg(5'h1d, 16'h0200);
    @(negedge mclk_in);
    chk("drive kept", 16'(reduce), 16'h0000);
    rd_chk(5'h1d, 16'h0200);
    u_sta.write_reg(5'h1d, 16'h0000);
    lvl[0] = 1'b1;
    repeat (3) @(negedge mclk_in);
    chk("drive linked", 16'(reduce), 16'h0000);
    complete_run();
  end
endmodule
